// >>> hdl/sdq_pair_buffer.sv
// Purpose: Small FIFO with valid/ready on both sides between filter and output.
// Assumes: Same clock on both sides.
// Notes: Simultaneous push and pop are allowed when neither empty nor full.
`timescale 1ns/10ps
`default_nettype none
module sdq_pair_buffer #(
  parameter int W = 18,
  parameter int DEPTH = 2
) (
  input wire logic clk, // Peripheral clock
  input wire logic reset, // Synchronous, active high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Drain accepts
  output logic [W-1:0] out_data // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= bump(wr_reg);
      end
      if (pop)
      begin
        rd_reg <= bump(rd_reg);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/sdq_pkg.sv
// Purpose: Shared constants for the sigma-delta sequencer and its buffer.
// Assumes: 50 MHz peripheral clock, single-bit modulator stream.
// Notes: Snapshot points split the 511-tap response into three boxes of 171.
package sdq_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 21;
  localparam int WIN_W = 9;
  localparam int PRE_W = 8;
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [WIN_W-1:0] WIN_LAST = 9'h1FF;
  localparam logic [WIN_W-1:0] WIN_RESET = 9'h000;
  localparam logic [WIN_W-1:0] SNAP_A = 9'h0A9;
  localparam logic [WIN_W-1:0] SNAP_B = 9'h154;
  localparam logic [1:0] SINGLE_KEEP = 2'h3;
  localparam logic [PRE_W-1:0] PRE_RESET = 8'h01;
  typedef enum logic [1:0] {SDQ_RESET_CYC, SDQ_FILTER, SDQ_HOLD} sdq_state_t;
endpackage

// >>> hdl/sdq_sequencer.sv
// Purpose: Sequencing and sinc3 decimation for a four-channel one-bit converter.
// Assumes: Control inputs are static or change from logic on clk.
// Notes: Results pass a two-entry buffer; a stalled drain holds the next window.
// Notes on behaviour
// - Four channels, one result register each.
// - Software picks round-robin or single-channel mode.
// - Round-robin holds each channel 512 oversampling cycles.
// - First window cycle resets modulator, clears filter.
// - Filter remaining bits; 16-bit result after 511.
// - Advance channel and repeat without stopping.
// - Third-order sinc, 511 taps, one-bit input.
// - Single mode routes one channel, restarts every 512; the first window after reset runs on channel 0.
// - Single mode keeps one result in four.
// - Oversampling clock is peripheral clock over prescaler.
// - 21-bit filter registers, keep top 16 bits.
// - Stored sample is signed two's complement.
// - Overrun flag when unread sample is overwritten.
`timescale 1ns/10ps
`default_nettype none
module sdq_sequencer #(
  parameter int PRE_WIDTH = sdq_pkg::PRE_W
) (
  input wire logic clk, // Peripheral clock two
  input wire logic reset, // Synchronous, active high
  input wire logic single_mode, // 1 selects single-channel mode
  input wire logic [1:0] single_chan, // Channel used in single mode
  input wire logic [PRE_WIDTH-1:0] prescale, // Oversampling divide factor, 0 acts as 1
  input wire logic mod_bit, // Modulator output pin
  input wire logic [3:0] sample_read, // Pulse: software read that channel
  input wire logic [3:0] overrun_clear, // Pulse: clear that overrun flag
  input wire logic avail_irq_en, // Enables the data-available request
  input wire logic out_ready, // Stream sink accepts
  output logic mod_reset, // Modulator reset, one oversampling cycle, longer while a result waits for buffer space
  output logic [1:0] mod_chan, // Input selector to the modulator
  output logic os_clk, // Oversampling clock to the modulator
  output logic [63:0] sample_bank, // Four 16-bit results, channel 0 lowest
  output logic [3:0] data_avail, // Unread result per channel
  output logic [3:0] overrun, // Sticky overrun per channel
  output logic avail_irq, // Data available and enabled
  output logic out_valid, // Stream word valid
  output logic [1:0] out_chan, // Stream word channel
  output logic [15:0] out_data // Stream word sample
);
  localparam int BW = sdq_pkg::CH_W + sdq_pkg::SAMPLE_W;
  localparam int AW = sdq_pkg::ACC_W;
  localparam int WW = sdq_pkg::WIN_W;

  logic [sdq_pkg::SYNC_STAGES-1:0] sync_reg;
  logic bit_reg;
  logic [PRE_WIDTH-1:0] pre_cnt_reg;
  logic tick;
  sdq_pkg::sdq_state_t state_reg;
  logic [sdq_pkg::WIN_W-1:0] win_reg;
  logic [1:0] rr_chan_reg;
  logic [1:0] quarter_reg;
  logic [AW-1:0] i1_reg;
  logic [AW-1:0] i2_reg;
  logic [AW-1:0] i3_reg;
  logic [AW-1:0] snap_a_reg;
  logic [AW-1:0] snap_b_reg;
  logic [AW-1:0] i1_next;
  logic [AW-1:0] i2_next;
  logic [AW-1:0] i3_next;
  logic [AW-1:0] result;
  logic res_valid_reg;
  logic [BW-1:0] res_word_reg;
  logic buf_in_ready;
  logic buf_valid;
  logic [BW-1:0] buf_data;
  logic take;
  logic store;
  logic [1:0] store_chan;

  function automatic logic [PRE_WIDTH-1:0] div_last(input logic [PRE_WIDTH-1:0] f);
    div_last = (f <= PRE_WIDTH'(1)) ? '0 : f - PRE_WIDTH'(1);
  endfunction

  function automatic logic [3:0] onehot(input logic [1:0] c);
    onehot = 4'h1 << c;
  endfunction

  // Three stages; a level counts once the last two agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync_reg <= '0;
      bit_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[sdq_pkg::SYNC_STAGES-2:0], mod_bit};
      if (sync_reg[1] == sync_reg[2])
      begin
        bit_reg <= sync_reg[2];
      end
    end
  end

  assign tick = (pre_cnt_reg == div_last(prescale));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_cnt_reg <= '0;
      os_clk <= 1'b0;
    end
    else
    begin
      pre_cnt_reg <= tick ? '0 : pre_cnt_reg + PRE_WIDTH'(1);
      os_clk <= (pre_cnt_reg < (prescale >> 1)) || (prescale <= PRE_WIDTH'(1));
    end
  end

  // Bit 1 feeds +1, bit 0 feeds -1, so mid-scale input integrates to zero
  assign i1_next = bit_reg ? i1_reg + AW'(1) : i1_reg - AW'(1);
  assign i2_next = i2_reg + i1_next;
  assign i3_next = i3_reg + i2_next;
  // Combs of length 171 evaluated at the two snapshot points; the fourth term is zero
  assign result = i3_next - AW'(3) * snap_b_reg + AW'(3) * snap_a_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= sdq_pkg::SDQ_RESET_CYC;
      win_reg <= sdq_pkg::WIN_RESET;
      rr_chan_reg <= '0;
      quarter_reg <= '0;
      mod_reset <= 1'b1;
      mod_chan <= '0;
    end
    else if (tick)
    begin
      case (state_reg)
        sdq_pkg::SDQ_RESET_CYC:
        begin
          // A result still waiting for buffer space keeps the modulator in reset
          if (!res_valid_reg || buf_in_ready)
          begin
            mod_reset <= 1'b0;
            win_reg <= win_reg + WW'(1);
            state_reg <= sdq_pkg::SDQ_FILTER;
          end
        end
        sdq_pkg::SDQ_FILTER:
        begin
          // No gap tick between windows, so a window with no buffer stall spans exactly 512 ticks
          if (win_reg == sdq_pkg::WIN_LAST)
          begin
            win_reg <= sdq_pkg::WIN_RESET;
            state_reg <= sdq_pkg::SDQ_RESET_CYC;
            mod_reset <= 1'b1;
            quarter_reg <= quarter_reg + 2'h1;
            rr_chan_reg <= rr_chan_reg + 2'h1;
            mod_chan <= single_mode ? single_chan : rr_chan_reg + 2'h1;
          end
          else
          begin
            win_reg <= win_reg + WW'(1);
          end
        end
        default:
        begin
          state_reg <= sdq_pkg::SDQ_RESET_CYC;
          win_reg <= sdq_pkg::WIN_RESET;
          mod_reset <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      snap_a_reg <= '0;
      snap_b_reg <= '0;
    end
    else if (tick && state_reg == sdq_pkg::SDQ_RESET_CYC)
    begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      snap_a_reg <= '0;
      snap_b_reg <= '0;
    end
    else if (tick && state_reg == sdq_pkg::SDQ_FILTER)
    begin
      i1_reg <= i1_next;
      i2_reg <= i2_next;
      i3_reg <= i3_next;
      if (win_reg == sdq_pkg::SNAP_A)
      begin
        snap_a_reg <= i3_next;
      end
      if (win_reg == sdq_pkg::SNAP_B)
      begin
        snap_b_reg <= i3_next;
      end
    end
  end

  // Single mode converts every window but keeps only the fourth
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      res_valid_reg <= 1'b0;
      res_word_reg <= '0;
    end
    else if (tick && state_reg == sdq_pkg::SDQ_FILTER && win_reg == sdq_pkg::WIN_LAST
             && (!single_mode || quarter_reg == sdq_pkg::SINGLE_KEEP))
    begin
      res_valid_reg <= 1'b1;
      res_word_reg <= {mod_chan, result[AW-1 -: sdq_pkg::SAMPLE_W]};
    end
    else if (buf_in_ready)
    begin
      res_valid_reg <= 1'b0;
    end
  end

  sdq_pair_buffer #(
    .W(BW),
    .DEPTH(sdq_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(res_valid_reg),
    .in_ready(buf_in_ready),
    .in_data(res_word_reg),
    .out_valid(buf_valid),
    .out_ready(take),
    .out_data(buf_data)
  );

  assign take = !out_valid || out_ready;
  assign store = buf_valid && take;
  assign store_chan = buf_data[BW-1 -: sdq_pkg::CH_W];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_chan <= '0;
      out_data <= '0;
      sample_bank <= '0;
    end
    else
    begin
      if (take)
      begin
        out_valid <= buf_valid;
      end
      if (store)
      begin
        out_chan <= store_chan;
        out_data <= buf_data[sdq_pkg::SAMPLE_W-1:0];
        sample_bank[store_chan*sdq_pkg::SAMPLE_W +: sdq_pkg::SAMPLE_W] <=
          buf_data[sdq_pkg::SAMPLE_W-1:0];
      end
    end
  end

  // Set wins over read or clear arriving in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_avail <= '0;
      overrun <= '0;
      avail_irq <= 1'b0;
    end
    else
    begin
      data_avail <= (data_avail & ~sample_read) | (store ? onehot(store_chan) : 4'h0);
      overrun <= (overrun & ~overrun_clear)
                 | (store ? onehot(store_chan) & data_avail & ~sample_read : 4'h0);
      avail_irq <= avail_irq_en && (|data_avail);
    end
  end
endmodule
`default_nettype wire

// >>> sim/sdq_mod_model.sv
// Purpose: Behavioural modulator with per-channel bit density.
// Assumes: One new bit per os_clk rise.
// Notes: Channel 1 leans positive, 2 negative, 0 balanced, 3 random.
`timescale 1ns/10ps
`default_nettype none
module sdq_mod_model (
  input wire logic analog_en, // Analog section powered
  input wire logic os_clk, // Oversampling clock
  input wire logic mod_reset, // Modulator reset
  input wire logic [1:0] mod_chan, // Selected input
  output logic mod_bit // Bitstream
);
  logic [4:0] ph = 5'h00;
  initial mod_bit = 1'b0;
  always @(posedge os_clk)
  begin
    ph <= (mod_reset || ph == 5'h13) ? 5'h00 : ph + 5'h01;
    // An unpowered modulator gives no usable stream
    if (!analog_en)
      mod_bit <= 1'b0;
    else
    case (mod_chan)
      2'h0: mod_bit <= ph[0];
      2'h1: mod_bit <= ph < 5'h0B;
      2'h2: mod_bit <= ph < 5'h09;
      default: mod_bit <= 1'($urandom);
    endcase
  end
endmodule
`default_nettype wire

// >>> sim/sdq_seq_props.sv
// Purpose: Port checker for sdq_sequencer.
// Assumes: Prescale only changes while reset is high.
// Notes: Bound to every sequencer instance.
`timescale 1ns/10ps
`default_nettype none
module sdq_seq_props #(
  parameter int PRE_WIDTH = 8
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic single_mode, // Mode
  input wire logic [PRE_WIDTH-1:0] prescale, // Divider
  input wire logic [3:0] sample_read, // Reads
  input wire logic avail_irq_en, // Enable
  input wire logic out_ready, // Sink ready
  input wire logic mod_reset, // Mod reset
  input wire logic [1:0] mod_chan, // Selector
  input wire logic os_clk, // Os clock
  input wire logic [3:0] data_avail, // Unread
  input wire logic [3:0] overrun, // Overrun
  input wire logic avail_irq, // Request
  input wire logic out_valid, // Valid
  input wire logic [1:0] out_chan, // Channel
  input wire logic [15:0] out_data // Data
);
  logic os_q;
  logic seen;
  logic [PRE_WIDTH-1:0] os_cnt;
  int low_cnt;
  // Clock cycles since the last rising edge of os_clk
  always_ff @(posedge clk)
  begin
    os_q <= os_clk;
    seen <= reset ? 1'b0 : (seen || (os_clk && !os_q));
    os_cnt <= (os_clk && !os_q) ? PRE_WIDTH'(1) : os_cnt + PRE_WIDTH'(1);
    low_cnt <= mod_reset ? 0 : low_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_stream_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_data) && $stable(out_chan)) else $error("stream word changed in stall");
  chk_reset_state: assert property (disable iff (1'b0) reset |=> mod_reset
    && mod_chan == 2'h0 && !out_valid) else $error("bad state after reset");
  chk_chan_reset: assert property ($changed(mod_chan) |-> mod_reset)
    else $error("selector moved outside reset cycle");
  chk_rr_order: assert property (!single_mode && $changed(mod_chan)
    |-> mod_chan == $past(mod_chan) + 2'h1) else $error("selector order wrong");
  chk_filter_span: assert property ($fell(mod_reset) |-> !mod_reset [*8])
    else $error("window too short");
  chk_window_len: assert property ($rose(mod_reset)
    |-> low_cnt == 511 * ((prescale > 1) ? int'(prescale) : 1)) else $error("window length wrong");
  chk_os_period: assert property (seen && os_clk && !os_q && prescale > 1
    |-> os_cnt == prescale) else $error("oversampling period wrong");
  chk_irq_follow: assert property (avail_irq == $past(avail_irq_en
    && data_avail != 4'h0)) else $error("request not following flags");
  chk_overrun_why: assert property ((overrun & ~$past(overrun)) != 4'h0
    |-> ((overrun & ~$past(overrun)) & ~($past(data_avail) & ~$past(sample_read))) == 4'h0)
    else $error("overrun without unread sample");
  cover property (single_mode && $rose(out_valid));
  cover property ($rose(overrun != 4'h0));
  cover property (out_valid && !out_ready [*8]);
endmodule
bind sdq_sequencer sdq_seq_props #(.PRE_WIDTH(PRE_WIDTH)) u_sdq_seq_props (.clk(clk),
  .reset(reset), .single_mode(single_mode), .prescale(prescale), .sample_read(sample_read),
  .avail_irq_en(avail_irq_en), .out_ready(out_ready), .mod_reset(mod_reset),
  .mod_chan(mod_chan), .os_clk(os_clk), .data_avail(data_avail), .overrun(overrun),
  .avail_irq(avail_irq), .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data));
`default_nettype wire

// >>> sim/tb_sdq_sequencer.sv
// Purpose: Self-checking bench for sdq_sequencer.
// Assumes: Modulator model on the far side.
// Notes: Prescale drawn from 2..4 so os_clk really toggles.
`timescale 1ns/10ps
`default_nettype none
module tb_sdq_sequencer;
  logic clk = 1'b0, reset = 1'b1, single_mode = 1'b0, avail_irq_en = 1'b1, out_ready = 1'b1;
  logic [1:0] single_chan = 2'h0, mod_chan, out_chan, ch, nx;
  logic [7:0] prescale = 8'h02;
  logic [3:0] sample_read = 4'h0, overrun_clear = 4'h0, data_avail, overrun;
  logic mod_bit, mod_reset, os_clk, avail_irq, out_valid;
  logic analog_en = 1'b0;
  logic [63:0] sample_bank;
  logic [15:0] d, out_data;
  int miscompares = 0, num_checks = 0;
  time t0, tp;
  always #10 clk = ~clk;
  sdq_sequencer u_sdq_sequencer (.clk(clk), .reset(reset), .single_mode(single_mode),
    .single_chan(single_chan), .prescale(prescale), .mod_bit(mod_bit),
    .sample_read(sample_read), .overrun_clear(overrun_clear), .avail_irq_en(avail_irq_en),
    .out_ready(out_ready), .mod_reset(mod_reset), .mod_chan(mod_chan), .os_clk(os_clk),
    .sample_bank(sample_bank), .data_avail(data_avail), .overrun(overrun),
    .avail_irq(avail_irq), .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data));
  sdq_mod_model u_sdq_mod_model (.analog_en(analog_en), .os_clk(os_clk), .mod_reset(mod_reset),
    .mod_chan(mod_chan), .mod_bit(mod_bit));
  function automatic int win_clk(int f, int n);
    return 512 * f * n;
  endfunction
  // Sign and size of a window result for each model density
  function automatic bit fits(logic [1:0] c, logic signed [15:0] v);
    return c == 2'h0 ? (v < 1000 && v > -1000) : c == 2'h1 ? v > 8000 : c == 2'h2 ? v < -8000 : 1;
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic sm, input logic [1:0] sc);
    @(posedge clk);
    #1 reset = 1'b1;
    single_mode = sm;
    single_chan = sc;
    prescale = 8'($urandom_range(4, 2));
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
  endtask
  // Handshake seen at the negedge lands on the following rising edge
  task automatic get_word();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!(out_valid && out_ready) && n < 40000);
    chk("word wait", 1, n < 40000);
    ch = out_chan;
    d = out_data;
    t0 = $time;
    @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(96));
    analog_en = 1'b1;
    do_reset(1'b0, 2'h0);
    for (int i = 0; i < 6; i++)
    begin
      get_word();
      chk("rr chan", i % 4, ch);
      chk("sample", 1, fits(ch, d));
      if (i > 0)
        chk("rr period", win_clk(prescale, 1), 32'((t0 - tp) / 20));
      tp = t0;
      repeat (4) @(posedge clk);
      chk("bank", d, sample_bank[ch*16 +: 16]);
    end
    chk("avail", 4'hF, data_avail);
    chk("overrun", 4'h3, overrun);
    chk("irq", 1, avail_irq);
    #1 sample_read = 4'hF;
    overrun_clear = 4'h3;
    @(posedge clk);
    #1 sample_read = 4'h0;
    overrun_clear = 4'h0;
    avail_irq_en = 1'b0;
    repeat (3) @(posedge clk);
    chk("cleared", 8'h00, {data_avail, overrun});
    get_word();
    repeat (4) @(posedge clk);
    chk("irq masked", 0, avail_irq);
    nx = ch + 2'h1;
    #1 out_ready = 1'b0;
    repeat (win_clk(prescale, 5)) @(posedge clk);
    #1 out_ready = 1'b1;
    // A stall must not drop or skip any window result
    for (int i = 0; i < 6; i++)
    begin
      get_word();
      chk("stall chan", nx, ch);
      nx = ch + 2'h1;
    end
    do_reset(1'b1, 2'($urandom));
    get_word();
    tp = t0;
    chk("single chan", single_chan, ch);
    get_word();
    chk("single chan", single_chan, ch);
    chk("single period", win_clk(prescale, 4), 32'((t0 - tp) / 20));
    end_sim();
  end
  initial
  begin
    #1800000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
